// ### src/sfw_pkg.sv
// Constants, enumerations and carrier types for the socket FIFO window block
package sfw_pkg;
	// Per-socket register offsets (socket 0), byte addresses
	localparam logic [15:0] SFW_CMD_OFS = 16'h8202;
	localparam logic [15:0] SFW_WRSZ_OFS = 16'h8222;
	localparam logic [15:0] SFW_RSR_HI_OFS = 16'h8228;
	localparam logic [15:0] SFW_RSR_LO_OFS = 16'h822A;
	localparam logic [15:0] SFW_FRAG_OFS = 16'h822C;
	localparam logic [15:0] SFW_TXW_OFS = 16'h822E;
	localparam logic [15:0] SFW_RXW_OFS = 16'h8230;
	localparam logic [15:0] SFW_SOCK_STRIDE = 16'h0040;
	// Reset values
	localparam logic [15:0] SFW_FRAG_RESET = 16'h0040;
	localparam logic [15:0] SFW_ZERO16 = 16'h0000;
	// Command codes in the low command byte
	localparam logic [7:0] SFW_CMD_SEND = 8'h20;
	localparam logic [7:0] SFW_CMD_RAW_MAC_SEND = 8'h21;
	localparam logic [7:0] SFW_CMD_RECEIVE_DONE = 8'h40;
	// Socket protocol field codes
	localparam logic [3:0] SFW_MODE_TCP = 4'h1;
	localparam logic [3:0] SFW_MODE_UDP = 4'h2;
	localparam logic [3:0] SFW_MODE_RAW_IP = 4'h3;
	localparam logic [3:0] SFW_MODE_RAW_ETHERNET = 4'h4;
	// Receive packet header lengths in bytes
	localparam logic [3:0] SFW_HDR_SHORT = 4'h2;
	localparam logic [3:0] SFW_HDR_UDP = 4'h8;
	localparam logic [3:0] SFW_HDR_RAW_IP = 4'h6;
	// Byte lane enables: even (lower) address byte sits in bits 15:8
	localparam logic [1:0] SFW_LANE_EVEN = 2'h2;
	localparam logic [1:0] SFW_LANE_ODD = 2'h1;
	localparam logic [1:0] SFW_LANE_BOTH = 2'h3;
	localparam logic [1:0] SFW_LANE_NONE = 2'h0;
	localparam int SFW_RSR_W = 17;
	localparam logic [16:0] SFW_RSR_STEP = 17'h00002;

	typedef enum logic [1:0] {SFW_TX_IDLE, SFW_TX_FETCH, SFW_TX_LATCH, SFW_TX_OUT} sfw_tx_st_t;
	typedef enum logic [1:0] {SFW_RX_IDLE, SFW_RX_DATA, SFW_RX_PAD, SFW_RX_HDR} sfw_rx_st_t;
	typedef enum logic [2:0] {
		SFW_RS_NONE, SFW_RS_FRAG, SFW_RS_TXW, SFW_RS_RXW, SFW_RS_RSRH, SFW_RS_RSRL, SFW_RS_WRSZ
	} sfw_rsel_t;

	// Host bus request, one-cycle strobes
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} sfw_host_req_t;

	// Received packet byte stream from the network side
	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
		logic [47:0] info;
	} sfw_net_rx_t;
endpackage

// ### src/sfw_word_ram.sv
// Word-wide socket buffer memory with byte lane writes and registered read
`timescale 1ns/100ps
module sfw_word_ram #(
	parameter int AW = 12
) (
	input wire logic clk_sys,
	input wire logic [1:0] we,
	input wire logic [AW-1:0] waddr,
	input wire logic [15:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [15:0] rdata_reg
);
	logic [15:0] mem [0:(1<<AW)-1];

	// Lane 1 is the lower-address byte; read data leaves through a register
	always_ff @(posedge clk_sys) begin
		if (we[1]) begin
			mem[waddr][15:8] <= wdata[15:8];
		end
		if (we[0]) begin
			mem[waddr][7:0] <= wdata[7:0];
		end
		rdata_reg <= mem[raddr];
	end
endmodule

// ### src/sfw_socket_window.sv
// Socket transmit/receive FIFO windows, fragment field and packet engines
//
// Function
// - Fragment field resets to don't-fragment, never fragments
// - Transmit window write-only unless memory test
// - Receive window read-only unless memory test
// - Transmit writes append low-then-high sequentially
// - Send transmits bytes in ascending address order
// - Receive reads return lower byte first, advance
// - Send code 20h, receive-done code 40h
// - Packet header with size precedes each packet
// - Header 2, 8 or 6 bytes by mode
// - Odd packets padded with one dummy byte
// - Bus width bit picks 16 or 8 bits
// - Word bits 15:8 hold the earlier byte
// - Each 16-bit or odd-byte receive window read lowers count by two
`timescale 1ns/100ps
module sfw_socket_window import sfw_pkg::*; #(
	parameter int AW = 12,
	parameter logic [3:0] SOCKET_INDEX = 4'h0
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire sfw_host_req_t host_req,
	input wire logic bus_width_bit,
	input wire logic memory_test_bit,
	input wire logic [3:0] socket_protocol_field,
	input wire sfw_net_rx_t net_rx,
	input wire logic tx_ready,
	output logic [15:0] host_rdata_reg,
	output logic host_rvalid_reg,
	output logic [15:0] frag_field_reg,
	output logic rx_ready_reg,
	output logic [7:0] tx_byte_reg,
	output logic tx_valid_reg,
	output logic tx_done_reg,
	output logic [16:0] rx_size_reg
);
	localparam int PW = AW + 1;
	localparam logic [15:0] SOCK_BASE = 16'(SFW_SOCK_STRIDE * SOCKET_INDEX);
	// Headroom keeps the engine from catching up with unreleased data
	localparam logic [PW-1:0] FILL_MAX = {PW{1'b1}} - PW'(15);

	typedef struct packed {
		logic [15:0] frag;
		logic [15:0] wrsize;
		logic [7:0] wr_low;
		logic [15:0] hold_word;
		logic [PW-1:0] tx_wptr;
		logic [PW-1:0] tx_rptr;
		logic [15:0] tx_left;
		sfw_tx_st_t tx_st;
		logic [15:0] tx_word;
		logic [7:0] tx_byte;
		logic tx_valid;
		logic tx_done;
		logic [PW-1:0] rx_wptr;
		logic [PW-1:0] rx_rptr;
		logic [PW-1:0] rx_rel;
		logic [PW-1:0] rx_start;
		logic [PW-1:0] rx_dptr;
		logic [15:0] rx_cnt;
		logic [3:0] rx_hlen;
		logic [1:0] rx_hidx;
		logic [47:0] rx_info;
		sfw_rx_st_t rx_st;
		logic rx_ready;
		logic [SFW_RSR_W-1:0] rsr;
		logic rd_pend;
		sfw_rsel_t rd_sel;
		logic rd_odd;
		logic [15:0] rdata;
		logic rvalid;
	} sfw_state_t;

	sfw_state_t s_reg;
	sfw_state_t s_next;
	logic [1:0] tx_we;
	logic [15:0] tx_wdata;
	logic [15:0] tx_rdata;
	logic [1:0] rx_we;
	logic [AW-1:0] rx_waddr;
	logic [15:0] rx_wdata;
	logic [15:0] rx_rdata;
	logic bus8_even;
	logic host_tx_rd;
	logic [7:0] cmd;
	logic [PW-1:0] used;

	// Address match on the word, so both byte registers hit
	function automatic logic hit(logic [15:0] a, logic [15:0] ofs);
		logic [15:0] t;
		t = ofs + SOCK_BASE;
		return a[15:1] == t[15:1];
	endfunction

	// byte or word write into a 16-bit register
	function automatic logic [15:0] merge(logic [15:0] old, logic [15:0] d, logic b16, logic odd);
		if (b16) begin
			return d;
		end else if (odd) begin
			return {old[15:8], d[7:0]};
		end
		return {d[7:0], old[7:0]};
	endfunction

	// Byte lane returned on an 8-bit read sits in bits 7:0
	function automatic logic [15:0] lane_pick(logic [15:0] v, logic b16, logic odd);
		if (b16) begin
			return v;
		end
		return {8'h00, odd ? v[7:0] : v[15:8]};
	endfunction

	function automatic logic [3:0] hdr_len(logic [3:0] mode);
		case (mode)
			SFW_MODE_UDP: return SFW_HDR_UDP;
			SFW_MODE_RAW_IP: return SFW_HDR_RAW_IP;
			default: return SFW_HDR_SHORT;
		endcase
	endfunction

	sfw_word_ram #(.AW(AW)) u_tx_ram (
		.clk_sys(clk_sys),
		.we(tx_we),
		.waddr(s_reg.tx_wptr[PW-1:1]),
		.wdata(tx_wdata),
		.raddr(s_reg.tx_rptr[PW-1:1]),
		.rdata_reg(tx_rdata)
	);

	sfw_word_ram #(.AW(AW)) u_rx_ram (
		.clk_sys(clk_sys),
		.we(rx_we),
		.waddr(rx_waddr),
		.wdata(rx_wdata),
		.raddr(s_reg.rx_rptr[PW-1:1]),
		.rdata_reg(rx_rdata)
	);

	// Host decode, transmit and receive engines
	always_comb begin
		s_next = s_reg;
		tx_we = SFW_LANE_NONE;
		tx_wdata = SFW_ZERO16;
		rx_we = SFW_LANE_NONE;
		rx_waddr = s_reg.rx_wptr[PW-1:1];
		rx_wdata = SFW_ZERO16;
		cmd = host_req.wdata[7:0];
		used = SFW_ZERO16[PW-1:0];
		bus8_even = ~bus_width_bit & ~host_req.addr[0];
		// transmit reads only in memory test
		host_tx_rd = host_req.rd & hit(host_req.addr, SFW_TXW_OFS) & memory_test_bit;
		s_next.rvalid = 1'b0;
		s_next.tx_done = 1'b0;
		s_next.rd_pend = 1'b0;

		// Second cycle of a read: memory word is now out of its register
		if (s_reg.rd_pend) begin
			s_next.rvalid = 1'b1;
			case (s_reg.rd_sel)
				SFW_RS_FRAG: s_next.rdata = lane_pick(s_reg.frag, bus_width_bit, s_reg.rd_odd);
				SFW_RS_WRSZ: s_next.rdata = lane_pick(s_reg.wrsize, bus_width_bit, s_reg.rd_odd);
				SFW_RS_RSRH: s_next.rdata = {15'h0000, s_reg.rsr[16]};
				SFW_RS_RSRL: s_next.rdata = lane_pick(s_reg.rsr[15:0], bus_width_bit, s_reg.rd_odd);
				SFW_RS_TXW, SFW_RS_RXW: begin
					// high byte of an 8-bit pair comes from the held word
					if (s_reg.rd_odd) begin
						s_next.rdata = lane_pick(s_reg.hold_word, 1'b0, 1'b1);
					end else begin
						s_next.hold_word = (s_reg.rd_sel == SFW_RS_TXW) ? tx_rdata : rx_rdata;
						s_next.rdata = lane_pick(s_next.hold_word, bus_width_bit, 1'b0);
					end
				end
				default: s_next.rdata = SFW_ZERO16;
			endcase
		end

		// Read request: pointers move when the pair completes
		if (host_req.rd) begin
			s_next.rd_pend = 1'b1;
			s_next.rd_odd = ~bus_width_bit & host_req.addr[0];
			s_next.rd_sel = SFW_RS_NONE;
			if (hit(host_req.addr, SFW_FRAG_OFS)) begin
				s_next.rd_sel = SFW_RS_FRAG;
			end else if (hit(host_req.addr, SFW_WRSZ_OFS)) begin
				s_next.rd_sel = SFW_RS_WRSZ;
			end else if (hit(host_req.addr, SFW_RSR_HI_OFS)) begin
				s_next.rd_sel = SFW_RS_RSRH;
			end else if (hit(host_req.addr, SFW_RSR_LO_OFS)) begin
				s_next.rd_sel = SFW_RS_RSRL;
			end else if (host_tx_rd) begin
				s_next.rd_sel = SFW_RS_TXW;
				if (!bus8_even) begin
					s_next.tx_rptr = s_reg.tx_rptr + PW'(2);
				end
			end else if (hit(host_req.addr, SFW_RXW_OFS)) begin
				s_next.rd_sel = SFW_RS_RXW;
				// two bytes off the received count per word read
				if (!bus8_even) begin
					s_next.rx_rptr = s_reg.rx_rptr + PW'(2);
					s_next.rsr = s_reg.rsr - SFW_RSR_STEP;
				end
			end
		end

		// Write request
		if (host_req.wr) begin
			// fragment field held only, never acted upon
			if (hit(host_req.addr, SFW_FRAG_OFS)) begin
				s_next.frag = merge(s_reg.frag, host_req.wdata, bus_width_bit, host_req.addr[0]);
			end
			if (hit(host_req.addr, SFW_WRSZ_OFS)) begin
				s_next.wrsize = merge(s_reg.wrsize, host_req.wdata, bus_width_bit, host_req.addr[0]);
			end
			// command codes in the lower command byte
			if (hit(host_req.addr, SFW_CMD_OFS) && !bus8_even) begin
				if ((cmd == SFW_CMD_SEND || cmd == SFW_CMD_RAW_MAC_SEND)
						&& s_reg.tx_st == SFW_TX_IDLE && s_reg.wrsize != SFW_ZERO16) begin
					s_next.tx_left = s_reg.wrsize;
					s_next.tx_st = SFW_TX_FETCH;
				end
				if (cmd == SFW_CMD_RECEIVE_DONE) begin
					s_next.rx_rel = s_reg.rx_rptr;
				end
			end
			if (bus8_even) begin
				s_next.wr_low = host_req.wdata[7:0];
			end
			// append pair, earlier byte in bits 15:8
			if (hit(host_req.addr, SFW_TXW_OFS) && !bus8_even) begin
				tx_we = SFW_LANE_BOTH;
				tx_wdata = bus_width_bit ? host_req.wdata : {s_reg.wr_low, host_req.wdata[7:0]};
				s_next.tx_wptr = s_reg.tx_wptr + PW'(2);
			end
			// receive writes only in memory test
			if (hit(host_req.addr, SFW_RXW_OFS) && !bus8_even && memory_test_bit) begin
				rx_we = SFW_LANE_BOTH;
				rx_wdata = bus_width_bit ? host_req.wdata : {s_reg.wr_low, host_req.wdata[7:0]};
				s_next.rx_wptr = s_reg.rx_wptr + PW'(2);
				s_next.rsr = s_next.rsr + SFW_RSR_STEP;
			end
		end

		// transmit engine walks memory upward one byte at a time
		case (s_reg.tx_st)
			SFW_TX_IDLE: begin
			end
			SFW_TX_FETCH: begin
				// Host test read owns the pointer this cycle
				if (!host_tx_rd) begin
					s_next.tx_st = SFW_TX_LATCH;
				end
			end
			SFW_TX_LATCH: begin
				s_next.tx_word = tx_rdata;
				s_next.tx_byte = s_reg.tx_rptr[0] ? tx_rdata[7:0] : tx_rdata[15:8];
				s_next.tx_valid = 1'b1;
				s_next.tx_st = SFW_TX_OUT;
			end
			SFW_TX_OUT: begin
				if (tx_ready) begin
					s_next.tx_left = s_reg.tx_left - 16'h0001;
					s_next.tx_rptr = s_reg.tx_rptr + PW'(1);
					if (s_reg.tx_left == 16'h0001) begin
						// Skip the dummy byte of an odd-length send
						s_next.tx_rptr = s_reg.tx_rptr + (s_reg.tx_rptr[0] ? PW'(1) : PW'(2));
						s_next.tx_valid = 1'b0;
						s_next.tx_done = 1'b1;
						s_next.tx_st = SFW_TX_IDLE;
					end else if (!s_reg.tx_rptr[0]) begin
						s_next.tx_byte = s_reg.tx_word[7:0];
					end else begin
						s_next.tx_valid = 1'b0;
						s_next.tx_st = SFW_TX_FETCH;
					end
				end
			end
			default: s_next.tx_st = SFW_TX_IDLE;
		endcase

		// receive engine: data after a reserved header, header last
		case (s_reg.rx_st)
			SFW_RX_IDLE: begin
				if (!memory_test_bit) begin
					s_next.rx_hlen = hdr_len(socket_protocol_field);
					s_next.rx_start = s_reg.rx_wptr;
					s_next.rx_dptr = s_reg.rx_wptr + PW'(s_next.rx_hlen);
					s_next.rx_cnt = SFW_ZERO16;
					s_next.rx_hidx = 2'h0;
					s_next.rx_st = SFW_RX_DATA;
				end
			end
			SFW_RX_DATA: begin
				if (net_rx.valid && s_reg.rx_ready) begin
					rx_we = s_reg.rx_dptr[0] ? SFW_LANE_ODD : SFW_LANE_EVEN;
					rx_waddr = s_reg.rx_dptr[PW-1:1];
					rx_wdata = {net_rx.data, net_rx.data};
					s_next.rx_dptr = s_reg.rx_dptr + PW'(1);
					s_next.rx_cnt = s_reg.rx_cnt + 16'h0001;
					if (net_rx.last) begin
						s_next.rx_info = net_rx.info;
						s_next.rx_st = s_next.rx_dptr[0] ? SFW_RX_PAD : SFW_RX_HDR;
					end
				end else if (s_reg.rx_cnt == SFW_ZERO16
						&& (memory_test_bit || hdr_len(socket_protocol_field) != s_reg.rx_hlen)) begin
					// Nothing stored yet: reserve the header again at the live pointer and mode
					s_next.rx_st = SFW_RX_IDLE;
				end
			end
			SFW_RX_PAD: begin
				// one dummy byte rounds an odd packet to a word
				rx_we = SFW_LANE_ODD;
				rx_waddr = s_reg.rx_dptr[PW-1:1];
				s_next.rx_dptr = s_reg.rx_dptr + PW'(1);
				s_next.rx_st = SFW_RX_HDR;
			end
			SFW_RX_HDR: begin
				rx_we = SFW_LANE_BOTH;
				rx_waddr = s_reg.rx_start[PW-1:1] + AW'(s_reg.rx_hidx);
				case (s_reg.rx_hidx)
					2'h0: rx_wdata = s_reg.rx_cnt;
					2'h1: rx_wdata = s_reg.rx_info[47:32];
					2'h2: rx_wdata = s_reg.rx_info[31:16];
					default: rx_wdata = s_reg.rx_info[15:0];
				endcase
				s_next.rx_hidx = s_reg.rx_hidx + 2'h1;
				if ({1'b0, s_reg.rx_hidx, 1'b0} + 4'h2 >= s_reg.rx_hlen) begin
					// Packet visible to the host only once its header is in place
					s_next.rx_wptr = s_reg.rx_dptr;
					s_next.rsr = s_next.rsr + SFW_RSR_W'(s_reg.rx_dptr - s_reg.rx_start);
					s_next.rx_st = SFW_RX_IDLE;
				end
			end
			default: s_next.rx_st = SFW_RX_IDLE;
		endcase

		// Stall the network side when space runs short or in memory test
		used = s_next.rx_dptr - s_reg.rx_rel;
		s_next.rx_ready = (s_next.rx_st == SFW_RX_DATA) && !memory_test_bit && (used < FILL_MAX);
	end

	// State register with synchronous reset
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_reg <= '0;
			s_reg.frag <= SFW_FRAG_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign host_rdata_reg = s_reg.rdata;
	assign host_rvalid_reg = s_reg.rvalid;
	assign frag_field_reg = s_reg.frag;
	assign rx_ready_reg = s_reg.rx_ready;
	assign tx_byte_reg = s_reg.tx_byte;
	assign tx_valid_reg = s_reg.tx_valid;
	assign tx_done_reg = s_reg.tx_done;
	assign rx_size_reg = s_reg.rsr;

	sequence s_tx_rd_blocked;
		host_req.rd && hit(host_req.addr, SFW_TXW_OFS) && !memory_test_bit;
	endsequence

	sequence s_rx_word_rd;
		host_req.rd && hit(host_req.addr, SFW_RXW_OFS) && bus_width_bit
			&& !(host_req.wr && memory_test_bit) && s_reg.rx_st != SFW_RX_HDR;
	endsequence

	a_frag_reset_value: assert property (@(posedge clk_sys)
		sys_rst |=> frag_field_reg == SFW_FRAG_RESET)
		else $error("fragment field reset value wrong");
	a_tx_read_blocked: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_tx_rd_blocked |-> ##2 host_rvalid_reg && host_rdata_reg == SFW_ZERO16)
		else $error("transmit window readable outside memory test");
	a_rx_write_blocked: assert property (@(posedge clk_sys) disable iff (sys_rst)
		host_req.wr && hit(host_req.addr, SFW_RXW_OFS) && !memory_test_bit
		&& s_reg.rx_st != SFW_RX_HDR |=> $stable(s_reg.rx_wptr))
		else $error("receive window written outside memory test");
	a_tx_append_seq: assert property (@(posedge clk_sys) disable iff (sys_rst)
		host_req.wr && hit(host_req.addr, SFW_TXW_OFS) && bus_width_bit
		|=> s_reg.tx_wptr == $past(s_reg.tx_wptr) + PW'(2))
		else $error("transmit write did not append");
	a_tx_ascending: assert property (@(posedge clk_sys) disable iff (sys_rst)
		tx_valid_reg && tx_ready && s_reg.tx_left != 16'h0001 && !host_tx_rd
		|=> s_reg.tx_rptr == $past(s_reg.tx_rptr) + PW'(1))
		else $error("transmit order not ascending");
	a_rx_count_dec: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_rx_word_rd |=> rx_size_reg == $past(rx_size_reg) - SFW_RSR_STEP)
		else $error("received count not lowered by two");
	a_rx_read_answer: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_rx_word_rd ##1 1'b1 |=> host_rvalid_reg && host_rdata_reg == $past(rx_rdata))
		else $error("receive word not returned in order");
	a_hdr_length: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_reg.rx_st == SFW_RX_DATA && s_reg.rx_cnt == SFW_ZERO16
		|-> s_reg.rx_dptr - s_reg.rx_start == PW'(s_reg.rx_hlen))
		else $error("header space has wrong length");
	a_pad_even_end: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_reg.rx_st == SFW_RX_HDR |-> !s_reg.rx_dptr[0])
		else $error("odd packet not padded");
	a_send_starts: assert property (@(posedge clk_sys) disable iff (sys_rst)
		host_req.wr && hit(host_req.addr, SFW_CMD_OFS) && bus_width_bit && cmd == SFW_CMD_SEND
		&& s_reg.tx_st == SFW_TX_IDLE && s_reg.wrsize != SFW_ZERO16
		|=> s_reg.tx_st == SFW_TX_FETCH ##2 tx_valid_reg)
		else $error("send command did not start");
endmodule

// ### testbench/sfw_host_model.sv
// Host processor model driving the socket window register bus
`timescale 1ns/100ps
module sfw_host_model import sfw_pkg::*; (
	input wire logic clk_sys,
	input wire logic [15:0] host_rdata_reg,
	input wire logic host_rvalid_reg,
	output sfw_host_req_t host_req
);
	// Bus idle from time zero
	initial begin
		host_req = '0;
	end

	// One access: strobe held for one sampling edge, read data waited for a bounded time
	task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
			output logic [15:0] q, output logic ok);
		int i;
		q = 16'h0000;
		ok = w;
		@(posedge clk_sys);
		host_req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk_sys);
		// Released lines show inverted values so stale data is never mistaken for live
		host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		for (i = 0; i < 6 && !ok; i++) begin
			@(negedge clk_sys);
			if (host_rvalid_reg === 1'b1) begin
				q = host_rdata_reg;
				ok = 1'b1;
			end
		end
		// A write returns off the edge, once its effect has settled
		if (w) begin
			@(negedge clk_sys);
		end
	endtask
endmodule

// ### testbench/sfw_socket_window_tb_top.sv
// Self-checking bench for the socket FIFO window block
`timescale 1ns/100ps
module sfw_socket_window_tb_top import sfw_pkg::*; ;
	typedef logic [7:0] sfw_bq_t[$];
	localparam logic [47:0] INFO = 48'h0123_4567_89AB;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic bus_width_bit = 1'b1;
	logic memory_test_bit = 1'b0;
	logic [3:0] socket_protocol_field = SFW_MODE_TCP;
	sfw_net_rx_t net_rx = '0;
	logic tx_ready = 1'b0;
	sfw_host_req_t host_req;
	logic [15:0] host_rdata_reg;
	logic host_rvalid_reg;
	logic [15:0] frag_field_reg;
	logic rx_ready_reg;
	logic [7:0] tx_byte_reg;
	logic tx_valid_reg;
	logic tx_done_reg;
	logic [16:0] rx_size_reg;
	int errors = 0;
	int samples_checked = 0;

	sfw_socket_window sfw_socket_window_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.host_req(host_req), .bus_width_bit(bus_width_bit), .memory_test_bit(memory_test_bit),
		.socket_protocol_field(socket_protocol_field), .net_rx(net_rx), .tx_ready(tx_ready),
		.host_rdata_reg(host_rdata_reg), .host_rvalid_reg(host_rvalid_reg),
		.frag_field_reg(frag_field_reg), .rx_ready_reg(rx_ready_reg), .tx_byte_reg(tx_byte_reg),
		.tx_valid_reg(tx_valid_reg), .tx_done_reg(tx_done_reg), .rx_size_reg(rx_size_reg));

	sfw_host_model sfw_host_model_inst (.clk_sys(clk_sys), .host_rdata_reg(host_rdata_reg),
		.host_rvalid_reg(host_rvalid_reg), .host_req(host_req));

	// 10 MHz system clock
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic conclude();
		$display("checks=%0d errors=%0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk_val(input logic [16:0] got, input logic [16:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// A wait that ran out ends the run at once
	task automatic fail_out();
		errors++;
		$display("ERROR t=%0t timeout got=%h exp=%h", $time, 1'b0, 1'b1);
		conclude();
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		logic [15:0] q;
		logic ok;
		sfw_host_model_inst.xfer(1'b1, a, d, q, ok);
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		logic [15:0] q;
		logic ok;
		sfw_host_model_inst.xfer(1'b0, a, 16'h0000, q, ok);
		if (!ok) fail_out();
		chk_val({1'b0, q}, {1'b0, exp});
	endtask

	// Collect transmit bytes with a stalling sink, then expect the done pulse
	task automatic exp_tx(input sfw_bq_t b);
		int i;
		int k;
		logic seen;
		k = 0;
		seen = 1'b0;
		for (i = 0; i < 300 && k < b.size(); i++) begin
			@(negedge clk_sys);
			if (tx_valid_reg === 1'b1 && tx_ready === 1'b1) begin
				chk_val({9'h000, tx_byte_reg}, {9'h000, b[k]});
				k++;
			end
			@(posedge clk_sys);
			tx_ready <= (i % 3 != 2);
		end
		if (k < b.size()) fail_out();
		for (i = 0; i < 4; i++) begin
			@(negedge clk_sys);
			seen |= (tx_done_reg === 1'b1);
		end
		chk_val({16'h0000, seen}, 17'h00001);
		chk_val({16'h0000, tx_valid_reg}, 17'h00000);
		@(posedge clk_sys);
		tx_ready <= 1'b0;
	endtask

	task automatic t_frag();
		chk_val({1'b0, frag_field_reg}, {1'b0, SFW_FRAG_RESET});
		rd(SFW_FRAG_OFS, SFW_FRAG_RESET);
		wr(SFW_FRAG_OFS, 16'h1234);
		rd(SFW_FRAG_OFS, 16'h1234);
		wr(SFW_FRAG_OFS, SFW_FRAG_RESET);
	endtask

	task automatic t_tx16();
		rd(SFW_TXW_OFS, SFW_ZERO16);
		wr(SFW_TXW_OFS, 16'h6162);
		wr(SFW_TXW_OFS, 16'h6364);
		wr(SFW_TXW_OFS, 16'h6500);
		wr(SFW_WRSZ_OFS, 16'h0005);
		wr(SFW_CMD_OFS, {8'h00, SFW_CMD_SEND});
		exp_tx('{8'h61, 8'h62, 8'h63, 8'h64, 8'h65});
	endtask

	// Byte-wide host: even register first, dummy byte pads the odd count
	task automatic t_tx8();
		@(posedge clk_sys);
		bus_width_bit <= 1'b0;
		wr(SFW_TXW_OFS, 16'h0061);
		wr(SFW_TXW_OFS + 16'h0001, 16'h0062);
		wr(SFW_TXW_OFS, 16'h0063);
		wr(SFW_TXW_OFS + 16'h0001, 16'h00EE);
		wr(SFW_WRSZ_OFS, 16'h0000);
		wr(SFW_WRSZ_OFS + 16'h0001, 16'h0003);
		wr(SFW_CMD_OFS + 16'h0001, {8'h00, SFW_CMD_RAW_MAC_SEND});
		exp_tx('{8'h61, 8'h62, 8'h63});
		@(posedge clk_sys);
		bus_width_bit <= 1'b1;
	endtask

	task automatic t_mt();
		@(posedge clk_sys);
		memory_test_bit <= 1'b1;
		wr(SFW_TXW_OFS, 16'hBEEF);
		rd(SFW_TXW_OFS, 16'hBEEF);
		rd(SFW_FRAG_OFS, SFW_FRAG_RESET);
		wr(SFW_RXW_OFS, 16'hA55A);
		chk_val(rx_size_reg, 17'h00002);
		rd(SFW_RXW_OFS, 16'hA55A);
		chk_val(rx_size_reg, 17'h00000);
		wr(SFW_CMD_OFS, {8'h00, SFW_CMD_RECEIVE_DONE});
		@(posedge clk_sys);
		memory_test_bit <= 1'b0;
		wr(SFW_RXW_OFS, 16'h1111);
		chk_val(rx_size_reg, 17'h00000);
	endtask

	// Receive "abcde" in one mode and read header then data back
	task automatic t_rx(input logic [3:0] mode, input int hdr, input logic w);
		sfw_bq_t b;
		logic [15:0] wd[$];
		logic [16:0] sz;
		int i;
		int n;
		b = '{8'h61, 8'h62, 8'h63, 8'h64, 8'h65};
		@(posedge clk_sys);
		socket_protocol_field <= mode;
		bus_width_bit <= w;
		i = 0;
		for (n = 0; n < 100 && i < 5; n++) begin
			@(posedge clk_sys);
			net_rx <= '{valid: 1'b1, last: (i == 4), data: b[i], info: INFO};
			@(negedge clk_sys);
			if (rx_ready_reg === 1'b1) i++;
		end
		@(posedge clk_sys);
		net_rx <= '{valid: 1'b0, last: 1'b0, data: 8'h9A, info: ~INFO};
		if (i < 5) fail_out();
		sz = 17'(hdr + 6);
		for (n = 0; n < 40 && rx_size_reg !== sz; n++) @(negedge clk_sys);
		chk_val(rx_size_reg, sz);
		wd.push_back(16'h0005);
		for (i = 1; i < hdr / 2; i++) wd.push_back(INFO[47 - 16 * (i - 1) -: 16]);
		wd.push_back(16'h6162);
		wd.push_back(16'h6364);
		wd.push_back(16'h6500);
		// Byte-wide bus: the fragment byte sits in the odd register
		rd(SFW_FRAG_OFS + {15'h0000, !w}, SFW_FRAG_RESET);
		for (i = 0; i < wd.size(); i++) begin
			if (w) begin
				rd(SFW_RXW_OFS, wd[i]);
			end else begin
				rd(SFW_RXW_OFS, {8'h00, wd[i][15:8]});
				rd(SFW_RXW_OFS + 16'h0001, {8'h00, wd[i][7:0]});
			end
			sz = sz - SFW_RSR_STEP;
			chk_val(rx_size_reg, sz);
		end
		wr(SFW_CMD_OFS + {15'h0000, !w}, {8'h00, SFW_CMD_RECEIVE_DONE});
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_frag();
		t_tx16();
		t_tx8();
		t_mt();
		t_rx(SFW_MODE_TCP, 2, 1'b1);
		t_rx(SFW_MODE_UDP, 8, 1'b1);
		t_rx(SFW_MODE_RAW_IP, 6, 1'b0);
		t_rx(SFW_MODE_RAW_ETHERNET, 2, 1'b0);
		conclude();
	end
endmodule
